// *** rtl/pcd_mux.v ***
/*
 * Alternate-function multiplexer for port C and port D pins with a
 * classic Wishbone register slave holding port and control bits.
 * Alternate functions override the port registers pin by pin, and
 * every pin and peripheral output is taken one flop after its cause.
 * Assumes all inputs are synchronous to clk_sys; fuses are static levels.
 */
`timescale 1ns/100ps
`include "pcd_mux_defs.vh"
module pcd_mux (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg         wb_ack_o,
	input  wire        wb_err_unused,
	input  wire [7:0]  portc_pin_i,
	output reg  [7:0]  portc_pin_o,
	output reg  [7:0]  portc_pin_oe,
	output reg  [7:0]  portc_pullup,
	input  wire [7:0]  portd_pin_i,
	output reg  [7:0]  portd_pin_o,
	output reg  [7:0]  portd_pin_oe,
	output reg  [7:0]  portd_pullup,
	input  wire        clkout_fuse,
	input  wire        reset_pin_disable_fuse,
	input  wire        debug_line_enable_fuse,
	input  wire        lock_bits_unprog,
	input  wire        osc_clock,
	input  wire        osc_amp_inverting,
	input  wire        timer16_match_a,
	input  wire        timer16_match_b,
	input  wire        serial_tx_data,
	input  wire        serial_clock_gen,
	input  wire        rts_level,
	input  wire        debug_tx_low,
	input  wire [7:0]  ext_irq_en,
	input  wire [12:8] pin_change_en,
	output reg         timer16_capture_in,
	output reg  [7:0]  ext_irq_in,
	output reg  [12:8] pin_change_in,
	output reg         ext_reset_n,
	output reg         debug_rx,
	output reg         timer8_count_in,
	output reg         serial_tx_allow,
	output reg         serial_rx_data,
	output reg         serial_sync_clock_in,
	output reg         comparator_pos_in,
	output reg         comparator_neg_in
);

////////////////////////////////////////////////////////////////////////////
// Registers reached over Wishbone.

reg [7:0] portc_out_r;
reg [7:0] portc_dir_r;
reg [7:0] portd_out_r;
reg [7:0] portd_dir_r;
reg [7:0] ctrl_r;
wire      req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire      wr  = req & wb_we_i & wb_sel_i[0];
wire      wr_pc_out = wr & (wb_adr_i == `PCD_ADR_PORTC_OUT);
wire      wr_pc_dir = wr & (wb_adr_i == `PCD_ADR_PORTC_DIR);
wire      wr_pd_out = wr & (wb_adr_i == `PCD_ADR_PORTD_OUT);
wire      wr_pd_dir = wr & (wb_adr_i == `PCD_ADR_PORTD_DIR);
wire      wr_ctrl   = wr & (wb_adr_i == `PCD_ADR_CTRL);
reg [7:0] rd_nxt;

////////////////////////////////////////////////////////////////////////////
// Read data selection.

always @* begin
	if (wb_adr_i == `PCD_ADR_PORTC_OUT) begin
		rd_nxt = portc_out_r;
	end else if (wb_adr_i == `PCD_ADR_PORTC_DIR) begin
		rd_nxt = portc_dir_r;
	end else if (wb_adr_i == `PCD_ADR_PORTD_OUT) begin
		rd_nxt = portd_out_r;
	end else if (wb_adr_i == `PCD_ADR_PORTD_DIR) begin
		rd_nxt = portd_dir_r;
	end else if (wb_adr_i == `PCD_ADR_CTRL) begin
		rd_nxt = ctrl_r;
	end else if (wb_adr_i == `PCD_ADR_PIN_C) begin
		rd_nxt = portc_pin_i & 8'hF7;
	end else if (wb_adr_i == `PCD_ADR_PIN_D) begin
		rd_nxt = portd_pin_i;
	end else begin
		rd_nxt = 8'h00;
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
	end else begin
		wb_ack_o <= req;
		if (req) begin
			wb_dat_o <= {24'h00_0000, rd_nxt};
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Port and control registers.

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		portc_out_r <= 8'h00;
		portc_dir_r <= 8'h00;
		portd_out_r <= 8'h00;
		portd_dir_r <= 8'h00;
		ctrl_r      <= `PCD_CTRL_RST;
	end else begin
		if (wr_pc_out) begin
			portc_out_r <= wb_dat_i[7:0] & 8'hF7;
		end
		if (wr_pc_dir) begin
			portc_dir_r <= wb_dat_i[7:0] & 8'hF7;
		end
		if (wr_pd_out) begin
			portd_out_r <= wb_dat_i[7:0];
		end
		if (wr_pd_dir) begin
			portd_dir_r <= wb_dat_i[7:0];
		end
		if (wr_ctrl) begin
			ctrl_r <= wb_dat_i[7:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Override signals per pin.

wire pud  = ctrl_r[`PCD_CTRL_PUD];
wire txen = ctrl_r[`PCD_CTRL_TXEN];
wire rxen = ctrl_r[`PCD_CTRL_RXEN];
wire sync = ctrl_r[`PCD_CTRL_SYNC];
wire flow = ctrl_r[`PCD_CTRL_FLOW];
wire rst_pin = reset_pin_disable_fuse;
wire dbg_pin = debug_line_enable_fuse & lock_bits_unprog;

reg [7:0] c_pullup_override_en;
reg [7:0] c_puov;
reg [7:0] c_direction_override_en;
reg [7:0] c_ddov;
reg [7:0] c_out_value_override_en;
reg [7:0] c_pvov;
reg [7:0] c_input_en_override_en;
reg [7:0] c_dieov;
reg [7:0] d_pullup_override_en;
reg [7:0] d_puov;
reg [7:0] d_direction_override_en;
reg [7:0] d_ddov;
reg [7:0] d_out_value_override_en;
reg [7:0] d_pvov;
reg [7:0] d_input_en_override_en;
reg [7:0] d_dieov;

always @* begin
	c_pullup_override_en = 8'h00;
	c_puov = 8'h00;
	c_direction_override_en = 8'h00;
	c_ddov = 8'h00;
	c_out_value_override_en = 8'h00;
	c_pvov = 8'h00;
	c_input_en_override_en = 8'h00;
	c_input_en_override_en[7] = ext_irq_en[4];
	c_input_en_override_en[6] = pin_change_en[8];
	c_input_en_override_en[5] = pin_change_en[9];
	c_input_en_override_en[4] = pin_change_en[10];
	c_input_en_override_en[2] = pin_change_en[11];
	c_dieov = 8'hF4;
	c_out_value_override_en[6] = ctrl_r[`PCD_CTRL_TIMER16_MATCH_A_OUT_EN];
	c_pvov[6] = timer16_match_a;
	c_out_value_override_en[5] = ctrl_r[`PCD_CTRL_TIMER16_MATCH_B_OUT_EN];
	c_pvov[5] = timer16_match_b;
	c_out_value_override_en[7] = clkout_fuse;
	c_pvov[7] = osc_clock;
	c_direction_override_en[7] = clkout_fuse;
	c_ddov[7] = 1'b1;
	c_direction_override_en[0] = ctrl_r[`PCD_CTRL_XTAL];
	c_ddov[0] = 1'b1;
	c_out_value_override_en[0] = ctrl_r[`PCD_CTRL_XTAL];
	c_pvov[0] = osc_amp_inverting;
	if (dbg_pin) begin
		c_pullup_override_en[1] = 1'b1;
		c_puov[1] = 1'b1;
		c_direction_override_en[1] = 1'b1;
		c_ddov[1] = debug_tx_low;
		c_out_value_override_en[1] = 1'b1;
		c_pvov[1] = 1'b0;
		c_input_en_override_en[1] = 1'b1;
		c_dieov[1] = 1'b1;
	end else if (rst_pin) begin
		c_pullup_override_en[1] = 1'b1;
		c_puov[1] = 1'b1;
		c_direction_override_en[1] = 1'b1;
		c_ddov[1] = 1'b0;
		c_input_en_override_en[1] = 1'b1;
		c_dieov[1] = 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////
// Port D overrides.

always @* begin
	d_pullup_override_en = 8'h00;
	d_puov = 8'h00;
	d_direction_override_en = 8'h00;
	d_ddov = 8'h00;
	d_out_value_override_en = 8'h00;
	d_pvov = 8'h00;
	d_input_en_override_en = 8'h00;
	d_input_en_override_en[7] = ext_irq_en[7] | flow;
	d_input_en_override_en[6] = ext_irq_en[6];
	d_input_en_override_en[5] = pin_change_en[12];
	d_input_en_override_en[4] = ext_irq_en[5];
	d_input_en_override_en[3] = ext_irq_en[3];
	d_input_en_override_en[2] = ext_irq_en[2];
	d_input_en_override_en[1] = ext_irq_en[1];
	d_dieov = 8'hFF;
	d_pullup_override_en[7] = flow;
	d_puov[7] = portd_out_r[7] & ~pud;
	d_direction_override_en[7] = flow;
	d_pullup_override_en[6] = flow;
	d_direction_override_en[6] = flow;
	d_ddov[6] = 1'b1;
	d_out_value_override_en[6] = flow;
	d_pvov[6] = rts_level;
	d_out_value_override_en[5] = sync & portd_dir_r[5];
	d_pvov[5] = serial_clock_gen;
	d_pullup_override_en[3] = txen;
	d_direction_override_en[3] = txen;
	d_ddov[3] = 1'b1;
	d_out_value_override_en[3] = txen;
	d_pvov[3] = serial_tx_data;
	d_pullup_override_en[2] = rxen;
	d_puov[2] = portd_out_r[2] & ~pud;
	d_direction_override_en[2] = rxen;
end

////////////////////////////////////////////////////////////////////////////
// Per-pin substitution of overrides, registered onto the pins.

genvar i;
generate
	for (i = 0; i < 8; i = i + 1) begin : g_pin_c
		always @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				portc_pin_o[i]  <= 1'b0;
				portc_pin_oe[i] <= 1'b0;
				portc_pullup[i] <= 1'b0;
			end else begin
				portc_pin_oe[i] <= c_direction_override_en[i] ? c_ddov[i] : portc_dir_r[i];
				portc_pin_o[i]  <= c_out_value_override_en[i] ? c_pvov[i] : portc_out_r[i];
				portc_pullup[i] <= c_pullup_override_en[i] ? c_puov[i] :
					(~portc_dir_r[i] & portc_out_r[i] & ~pud);
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Port D pins.

generate
	for (i = 0; i < 8; i = i + 1) begin : g_pin_d
		always @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				portd_pin_o[i]  <= 1'b0;
				portd_pin_oe[i] <= 1'b0;
				portd_pullup[i] <= 1'b0;
			end else begin
				portd_pin_oe[i] <= d_direction_override_en[i] ? d_ddov[i] : portd_dir_r[i];
				portd_pin_o[i]  <= d_out_value_override_en[i] ? d_pvov[i] : portd_out_r[i];
				portd_pullup[i] <= d_pullup_override_en[i] ? d_puov[i] :
					(~portd_dir_r[i] & portd_out_r[i] & ~pud);
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Inputs toward the peripherals.

wire [7:0] c_in = portc_pin_i & (c_input_en_override_en & c_dieov);
wire [7:0] d_in = portd_pin_i & (d_input_en_override_en & d_dieov);

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		timer16_capture_in <= 1'b0;
		ext_irq_in         <= 8'h00;
		pin_change_in      <= 5'h00;
	end else begin
		timer16_capture_in <= portc_pin_i[7];
		ext_irq_in[7]      <= portd_pin_i[7] & ext_irq_en[7];
		ext_irq_in[6]      <= d_in[6];
		ext_irq_in[5]      <= d_in[4];
		ext_irq_in[4]      <= c_in[7];
		ext_irq_in[3]      <= d_in[3];
		ext_irq_in[2]      <= d_in[2];
		ext_irq_in[1]      <= d_in[1];
		ext_irq_in[0]      <= 1'b0;
		pin_change_in[12]  <= d_in[5];
		pin_change_in[11]  <= c_in[2];
		pin_change_in[10]  <= c_in[4];
		pin_change_in[9]   <= c_in[5];
		pin_change_in[8]   <= c_in[6];
	end
end

////////////////////////////////////////////////////////////////////////////
// Reset and debug line inputs.

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		ext_reset_n <= 1'b1;
		debug_rx    <= 1'b1;
	end else begin
		ext_reset_n <= ~(rst_pin & ~dbg_pin) | portc_pin_i[1];
		debug_rx    <= ~dbg_pin | portc_pin_i[1];
	end
end

////////////////////////////////////////////////////////////////////////////
// Timer, serial and comparator inputs.

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		timer8_count_in      <= 1'b0;
		serial_tx_allow      <= 1'b1;
		serial_rx_data       <= 1'b1;
		serial_sync_clock_in <= 1'b0;
		comparator_pos_in    <= 1'b0;
		comparator_neg_in    <= 1'b0;
	end else begin
		timer8_count_in <= portd_pin_i[7];
		serial_tx_allow <= ~flow | ~portd_pin_i[7];
		serial_rx_data <= portd_pin_i[2];
		serial_sync_clock_in <= sync & ~portd_dir_r[5] & portd_pin_i[5];
		comparator_pos_in <= portd_pin_i[1];
		comparator_neg_in <= portd_pin_i[2];
	end
end

endmodule

// *** rtl/pcd_mux_defs.vh ***
/*
 * Constants for the port C and port D alternate-function multiplexer.
 * Assumes a single clk_sys domain and a classic Wishbone register slave.
 */
// Notes on behaviour
// - Port C pin 7 feeds the 16-bit timer capture input.
// - External interrupts 1..3 and 5..7 on port D, source 4 on port C pin 7, gated.
// - Port C pin 7 drives the oscillator clock when the clock-out fuse is set.
// - Compare A and B pins also carry the PWM waveforms.
// - Pin-change sources 8..11 on port C pins 6,5,4,2; 12 on port D pin 5.
// - Port C pin 1 is active-low reset while the reset-disable fuse reads 1.
// - As reset pin: pull-up on, driver off, digital input off.
// - Debug fuse programmed and unlocked makes reset pin open-drain debug line.
// - Port C pin 0 can be the oscillator amplifier inverting output.
// - Port D pin 7 is the 8-bit timer external count input.
// - Port D pin 7 is clear-to-send, gating the transmitter under flow control.
// - Port D pin 6 is request-to-send for the receiver under flow control.
// - Serial clock pin direction follows its direction bit.
// - Serial clock pin is active only in synchronous mode.
// - Transmitter enabled forces the transmit pin to output.
// - Receiver enabled forces the receive pin to input.
// - Forced receive input keeps its pull-up under the port data bit.
// - Port D pin 2 to comparator negative, pin 1 to positive.
`ifndef PCD_MUX_DEFS_VH
`define PCD_MUX_DEFS_VH
`define PCD_ADR_PORTC_OUT 8'h00
`define PCD_ADR_PORTC_DIR 8'h04
`define PCD_ADR_PORTD_OUT 8'h08
`define PCD_ADR_PORTD_DIR 8'h0C
`define PCD_ADR_CTRL      8'h10
`define PCD_ADR_PIN_C     8'h14
`define PCD_ADR_PIN_D     8'h18
`define PCD_CTRL_RST      8'h00
`define PCD_CTRL_PUD      0
`define PCD_CTRL_TIMER16_MATCH_A_OUT_EN  1
`define PCD_CTRL_TIMER16_MATCH_B_OUT_EN  2
`define PCD_CTRL_TXEN     3
`define PCD_CTRL_RXEN     4
`define PCD_CTRL_SYNC     5
`define PCD_CTRL_FLOW     6
`define PCD_CTRL_XTAL     7
`endif

// *** tb/pcd_board.sv ***
/* Board side of one 8-bit port: resolves each pin's level.
   Assumes the bench chooses which pins the board drives. */
`timescale 1ns/100ps
module pcd_board (
	input	logic		clk,
	input	logic [7:0]	oe,
	input	logic [7:0]	o,
	input	logic [7:0]	pu,
	input	logic [7:0]	drv,
	input	logic [7:0]	ext,
	output	logic [7:0]	lvl
);
	logic [7:0] last_r = 8'h00;
	// An undriven pin goes to its pull-up or keeps flipping.
	always_comb begin
		for (int i = 0; i < 8; i++)
			lvl[i] = oe[i] ? o[i] : drv[i] ? ext[i] : pu[i] | ~last_r[i];
	end
	always @(posedge clk) begin
		last_r <= lvl;
	end
endmodule

// *** tb/pcd_mux_props.sv ***
/* Checker for the pin routing and bus answer of pcd_mux.
   Assumes one clk_sys domain with rst asynchronous, active high. */
`timescale 1ns/100ps
module pcd_chk (
	input	logic		clk_sys,
	input	logic		rst,
	input	logic		wb_cyc_i,
	input	logic		wb_stb_i,
	input	logic		wb_ack_o,
	input	logic [7:0]	portc_pin_i,
	input	logic [7:0]	portd_pin_i,
	input	logic [7:0]	portc_pin_o,
	input	logic [7:0]	portc_pin_oe,
	input	logic [7:0]	portc_pullup,
	input	logic		clkout_fuse,
	input	logic		reset_pin_disable_fuse,
	input	logic		debug_line_enable_fuse,
	input	logic		lock_bits_unprog,
	input	logic		osc_clock,
	input	logic		debug_tx_low,
	input	logic [7:0]	ext_irq_en,
	input	logic [12:8]	pin_change_en,
	input	logic		timer16_capture_in,
	input	logic [7:0]	ext_irq_in,
	input	logic [12:8]	pin_change_in,
	input	logic		ext_reset_n,
	input	logic		timer8_count_in,
	input	logic		debug_rx,
	input	logic		serial_rx_data,
	input	logic		comparator_pos_in,
	input	logic		comparator_neg_in
);
	logic live_r;
	wire dbg = debug_line_enable_fuse & lock_bits_unprog;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	always @(posedge clk_sys or posedge rst) begin
		live_r <= !rst;
	end
	////////////////////////////////////////
	a_capture_pin: assert property (live_r |->
		timer16_capture_in == $past(portc_pin_i[7])) else $error("capture");
	a_irq_gate: assert property (live_r |-> ext_irq_in[4] ==
		$past(portc_pin_i[7] & ext_irq_en[4]) && !ext_irq_in[0] &&
		ext_irq_in[7] == $past(portd_pin_i[7] & ext_irq_en[7])) else $error("irq");
	a_change_srcs: assert property (live_r |-> pin_change_in == $past({
		portd_pin_i[5], portc_pin_i[2], portc_pin_i[4], portc_pin_i[5],
		portc_pin_i[6]} & pin_change_en)) else $error("pin change");
	a_reset_pin: assert property (live_r && $past(reset_pin_disable_fuse
		& !dbg) |-> ext_reset_n == $past(portc_pin_i[1]) &&
		portc_pullup[1] && !portc_pin_oe[1]) else $error("reset pin");
	a_debug_drain: assert property (live_r && $past(dbg) |->
		portc_pullup[1] && !portc_pin_o[1] &&
		portc_pin_oe[1] == $past(debug_tx_low)) else $error("debug line");
	a_clock_out: assert property (live_r && $past(clkout_fuse) |->
		portc_pin_oe[7] && portc_pin_o[7] == $past(osc_clock))
		else $error("clock out");
	a_count_in: assert property (live_r |->
		timer8_count_in == $past(portd_pin_i[7])) else $error("count in");
	a_irq_port_d: assert property (live_r |-> ext_irq_in[6:5] ==
		$past({portd_pin_i[6] & ext_irq_en[6], portd_pin_i[4] & ext_irq_en[5]})
		&& ext_irq_in[3:1] == $past(portd_pin_i[3:1] & ext_irq_en[3:1]))
		else $error("irq port d");
	a_rx_comp: assert property (live_r |->
		serial_rx_data == $past(portd_pin_i[2]) &&
		comparator_neg_in == $past(portd_pin_i[2]) &&
		comparator_pos_in == $past(portd_pin_i[1])) else $error("rx comp");
	a_debug_rx: assert property (live_r |->
		debug_rx == $past(!dbg | portc_pin_i[1])) else $error("debug rx");
	a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
		wb_ack_o ##1 !wb_ack_o) else $error("ack");
	c_ack: cover property (wb_ack_o);
	c_debug: cover property (dbg && debug_tx_low);
	c_clock: cover property (clkout_fuse && live_r);
endmodule
bind pcd_mux pcd_chk pcd_chk_inst (.*);

// *** tb/tb.sv ***
/* Self-checking bench for pcd_mux over classic Wishbone.
   Assumes pcd_board for the pins and a bound checker. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin $display(\
"unexpected t=%0t got=%h exp=%h", $time, g, e); bad_count++; end end
module tb;
	logic clk_sys = 0, rst = 1, probe, wb_we_i, wb_cyc_i, wb_stb_i;
	logic wb_err_unused, wb_ack_o, clkout_fuse, reset_pin_disable_fuse;
	logic debug_line_enable_fuse, lock_bits_unprog, osc_clock, debug_rx;
	logic osc_amp_inverting, timer16_match_a, timer16_match_b, rts_level;
	logic serial_tx_data, serial_clock_gen, debug_tx_low, ext_reset_n;
	logic timer16_capture_in, timer8_count_in, serial_tx_allow;
	logic serial_rx_data, serial_sync_clock_in, comparator_pos_in;
	logic comparator_neg_in;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, seed = 32'h0000_09f2;
	logic [12:8] pin_change_en, pin_change_in;
	logic [7:0] wb_adr_i, portc_pin_i, portc_pin_o, portc_pin_oe, portc_pullup;
	logic [7:0] portd_pin_i, portd_pin_o, portd_pin_oe, portd_pullup, xc, xd;
	logic [7:0] ext_irq_en, ext_irq_in, oc, od, dc, dd, ct, d;
	logic [10:0] q[$], e;
	int bad_count = 0, n_tests = 0;
	wire [39:0] obs = {serial_tx_allow, serial_sync_clock_in, portd_pullup[2],
		5'h00, portc_pin_o & 8'hf5, portd_pin_oe, portd_pin_o, wb_dat_o[7:0]};
	pcd_mux pcd_mux_inst (.*);
	pcd_board pcd_board_c (.clk(clk_sys), .oe(portc_pin_oe), .o(portc_pin_o),
		.pu(portc_pullup), .drv(8'hfd), .ext(xc), .lvl(portc_pin_i));
	pcd_board pcd_board_d (.clk(clk_sys), .oe(portd_pin_oe), .o(portd_pin_o),
		.pu(portd_pullup), .drv(8'hff), .ext(xd), .lvl(portd_pin_i));
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wrap_up();
		if (bad_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wb(input logic [7:0] a, dv, input logic w, [3:0] s);
		int n;
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <=
			{2'b11, w, s, a, 24'h00_0000, dv};
		for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_sys);
		if (n == 20) begin
			bad_count++;
			wrap_up();
		end else begin
			{wb_cyc_i, wb_stb_i} <= 2'b00;
		end
	endtask
	task automatic rd(input logic [7:0] a, ev);
		q.push_back({3'd0, ev});
		wb(a, 8'h00, 0, 4'h1);
	endtask
	task automatic look(input logic [2:0] s, input logic [7:0] ev);
		repeat (3) @(posedge clk_sys);
		q.push_back({s, ev});
		probe <= 1;
		@(posedge clk_sys);
		probe <= 0;
	endtask
	task automatic rnd_in();
		logic [63:0] r;
		r = {xs(), xs()};
		{clkout_fuse, reset_pin_disable_fuse, debug_line_enable_fuse, osc_clock,
			osc_amp_inverting, timer16_match_a, timer16_match_b, serial_tx_data,
			serial_clock_gen, rts_level, debug_tx_low, ext_irq_en, pin_change_en,
			xc, xd, lock_bits_unprog} <= r[40:0];
	endtask
	always @(posedge clk_sys) begin
		if ((wb_ack_o && !wb_we_i) || probe) begin
			e = q.pop_front();
			`CHK(obs[8 * e[10:8] +: 8], e[7:0])
		end
	end
	initial begin
		{probe, wb_we_i, wb_cyc_i, wb_stb_i, wb_err_unused, wb_sel_i} = 0;
		{wb_adr_i, wb_dat_i, lock_bits_unprog} = 1;
		rnd_in();
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		for (int a = 0; a < 32; a += 4) if (a != 20 && a != 24) rd(a, 0);
		for (int a = 0; a < 20; a += 4) begin
			d = xs();
			wb(a, d, 1, 4'h1);
			wb(a, ~d, 1, 4'h0);
			rd(a, a < 8 ? d & 8'hf7 : d);
			wb(a, 8'h00, 1, 4'h1);
		end
		wb(8'h1c, 8'hff, 1, 4'h1);
		rd(8'h1c, 0);
		rnd_in();
		repeat (3) @(posedge clk_sys);
		rd(8'h18, xd);
		repeat (12) begin
			{oc, od, ct} = {xs(), xs()};
			{dc, dd} = xs() | 16'h6000;
			dd[7] = 0;
			wb(8'h00, oc, 1, 4'h1);
			wb(8'h04, dc, 1, 4'h1);
			wb(8'h08, od, 1, 4'h1);
			wb(8'h0c, dd, 1, 4'h1);
			wb(8'h10, ct, 1, 4'h1);
			rnd_in();
			@(posedge clk_sys);
			look(1, {od[7], ct[6] ? rts_level : od[6], ct[5] & dd[5] ?
				serial_clock_gen : od[5], od[4], ct[3] ? serial_tx_data :
				od[3], od[2:0]});
			look(2, {1'b0, ct[6] | dd[6], dd[5:4], ct[3] | dd[3],
				dd[2] & !ct[4], dd[1:0]});
			look(3, {clkout_fuse ? osc_clock : oc[7], ct[1] ?
				timer16_match_a : oc[6], ct[2] ? timer16_match_b : oc[5],
				oc[4], 1'b0, oc[2], 1'b0, ct[7] ? osc_amp_inverting : oc[0]});
			look(4, {!ct[6] | !xd[7], ct[5] & !dd[5] & xd[5],
				(ct[4] | !dd[2]) & od[2] & !ct[0], 5'h00});
		end
		wrap_up();
	end
endmodule
